// ---- rtl/adcsp_pkg.sv ----
// constants, states and frame layout of the adc serial readout port
// assumes: a 125 MHz system clock and a host-driven serial clock
package adcsp_pkg;
  // system and oscillator rates, in kHz
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int OSC_FREQ_KHZ = 4000;
  // internal oscillator modelled as a divider of the system clock
  localparam int OSC_DIV = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
  // allowed serial clock range, in kHz
  localparam int SCLK_MIN_KHZ = 100;
  localparam int SCLK_MAX_KHZ = 4800;
  // conversion length in oscillator ticks (internal clock mode)
  localparam int CONV_OSC_TICKS = 4;
  // rising serial edge that ends conversion (external clock mode)
  localparam logic [4:0] EXT_CONV_EDGE = 5'h04;
  // frame layout: zero byte, result, trailing flags
  localparam int RES_BITS = 16;
  localparam int FLAG_BITS = 2;
  localparam int WORD_BITS = RES_BITS + FLAG_BITS;
  localparam logic [4:0] LEAD_ZERO_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h1A;
  localparam int FIFO_DEPTH = 16;
  // reset values
  localparam logic [WORD_BITS-1:0] WORD_RST = 18'h00000;
  localparam logic [4:0] CNT_RST = 5'h00;

  // conversion sequencer, gray along idle -> conv -> load
  typedef enum logic [1:0] {
    ADCSP_IDLE = 2'b00,
    ADCSP_CONV = 2'b01,
    ADCSP_LOAD = 2'b11
  } adcsp_state_t;
endpackage

// ---- rtl/adcsp_stream_if.sv ----
// valid/ready word stream between the block's own modules
// assumes: both ends on the system clock
`timescale 1ns/1ps
interface adcsp_stream_if #(
  parameter int W = 18
);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ---- rtl/adcsp_fifo.sv ----
// synchronous fifo for conversion words, valid/ready on both sides
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module adcsp_fifo
  import adcsp_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
)(
  input wire logic clk,
  input wire logic reset,
  adcsp_stream_if.snk wr,
  adcsp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic not_full_r;
  logic push;
  logic pop;

  // ready is registered so the top can export it from a flop
  assign wr.ready = not_full_r;
  assign rd.valid = (count_r != '0);
  assign rd.data = mem[rd_ptr_r];
  assign push = wr.valid & not_full_r;
  assign pop = rd.valid & rd.ready;

  // occupancy; simultaneous push and pop leave it unchanged
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // storage, no reset needed on the data itself
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= wr.data;
  end

  // pointers and flags
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      not_full_r <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_nxt;
      not_full_r <= (count_nxt != DEPTH_C);
    end
  end
endmodule

// ---- rtl/adcsp_osc.sv ----
// internal conversion oscillator and tick counter
// assumes: run is held for the whole conversion, dropped to stop it
`timescale 1ns/1ps
module adcsp_osc
  import adcsp_pkg::*;
#(
  parameter int DIV = OSC_DIV,
  parameter int TICKS = CONV_OSC_TICKS
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic done
);
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] TICK_LAST = 8'(TICKS - 1);

  logic [7:0] div_r;
  logic [7:0] tick_r;
  logic done_r;

  assign done = done_r;

  // counters sit at zero while stopped, so no tick leaks out
  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      div_r <= '0;
      tick_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (div_r == DIV_LAST)
      begin
        div_r <= '0;
        if (tick_r == TICK_LAST)
          done_r <= 1'b1;
        else
          tick_r <= tick_r + 1'b1;
      end
      else
        div_r <= div_r + 1'b1;
    end
  end
endmodule

// ---- rtl/adcsp_top.sv ----
// serial readout port of a multichannel successive-approximation adc
// assumes: host is a mode 0 serial master; results arrive from the
// analog core on clk; sclk and cs_n are asynchronous pins
//
// Overview of operation
// R1 - conversions timed by serial clock or internal oscillator per mode
// R2 - serial data shifts only on the host serial clock
// R3 - internal mode: oscillator sequences conversion, ignoring serial edges
// R4 - external mode: internal oscillator stays stopped throughout
// R5 - host should stop serial clock while oscillator runs; the host model clocks four edges first
// R6 - host waits 5 ms after wake with internal reference
// R7 - link uses polarity zero, phase zero; clock idles low
// R8 - host drives chip select low to power up first
// R9 - host reads one result in three back-to-back bytes; the host model pauses after the fourth clock and clocks 26 bits
// R10 - output changes only on serial clock falling edges
// R11 - zero byte, then result msb first, then two trailing flags
// R12 - serial clock may run up to 4.8 MHz; the host model clocks at a 12 ns period
// R13 - host samples input mid bit with sample phase cleared
// R14 - results are straight binary, zero input gives zero
// R15 - host keeps chip select low for all three bytes
`timescale 1ns/1ps
module adcsp_top
  import adcsp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic int_clk_mode,
  input wire logic [RES_BITS-1:0] adc_data,
  input wire logic [FLAG_BITS-1:0] adc_flags,
  input wire logic adc_valid,
  output logic adc_ready,
  output logic dout,
  output logic powered,
  output logic conv_busy,
  output logic osc_running
);
  // system clock domain: sequencer, fifo and status
  adcsp_stream_if #(.W(WORD_BITS)) in_if ();
  adcsp_stream_if #(.W(WORD_BITS)) out_if ();

  adcsp_state_t state_r;
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic req_meta_r;
  logic req_sync_r;
  logic req_prev_r;
  logic mode_meta_r;
  logic mode_sync_r;
  logic mode_r;
  logic powered_r;
  logic busy_r;
  logic osc_run_r;
  logic result_valid_r;
  logic [WORD_BITS-1:0] result_r;
  logic osc_done;
  logic cs_fall;
  logic cs_rise;
  logic ext_done;
  logic take;
  // set on the serial side, read here only by req_meta_r
  logic conv_req_r;

  // straight binary word, flags in the low two bits
  assign in_if.data = {adc_data, adc_flags}; // [R14]
  assign in_if.valid = adc_valid;
  assign adc_ready = in_if.ready;
  assign out_if.ready = (state_r == ADCSP_LOAD) & ~cs_sync_r;
  assign take = out_if.valid & out_if.ready;

  adcsp_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .wr(in_if.snk),
    .rd(out_if.src)
  );

  // oscillator only runs in internal mode during a conversion
  adcsp_osc u_osc (
    .clk(clk),
    .reset(reset),
    .run(osc_run_r),
    .done(osc_done)
  );

  // two-flop synchronisers for chip select, mode pin and request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      req_prev_r <= 1'b0;
      mode_meta_r <= 1'b0;
      mode_sync_r <= 1'b0;
    end
    else
    begin
      cs_meta_r <= cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      req_meta_r <= conv_req_r;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
      mode_meta_r <= int_clk_mode;
      mode_sync_r <= mode_meta_r;
    end
  end

  assign cs_fall = cs_prev_r & ~cs_sync_r;
  assign cs_rise = ~cs_prev_r & cs_sync_r;
  // external mode: conversion ends on a counted serial edge
  assign ext_done = req_sync_r & ~req_prev_r;

  // conversion sequencer; chip select high aborts at any point
  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= ADCSP_IDLE;
    else if (cs_rise)
      state_r <= ADCSP_IDLE;
    else
    begin
      unique case (state_r)
        ADCSP_IDLE:
          if (cs_fall) // [R8]
            state_r <= ADCSP_CONV;
        ADCSP_CONV:
          if (mode_r ? osc_done : ext_done) // [R1] [R3]
            state_r <= ADCSP_LOAD;
        ADCSP_LOAD:
          if (take)
            state_r <= ADCSP_IDLE;
        default:
          state_r <= ADCSP_IDLE;
      endcase
    end
  end

  // clock mode is captured when chip select falls
  always_ff @(posedge clk)
  begin
    if (reset)
      mode_r <= 1'b0;
    else if (cs_fall)
      mode_r <= mode_sync_r; // [R1]
  end

  // oscillator gate: never on in external clock mode
  always_ff @(posedge clk)
  begin
    if (reset)
      osc_run_r <= 1'b0;
    else
      osc_run_r <= mode_r & (state_r == ADCSP_CONV) & ~cs_rise; // [R4]
  end

  // status flops exported as outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      powered_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      powered_r <= ~cs_sync_r;
      busy_r <= (state_r != ADCSP_IDLE) & ~cs_rise;
    end
  end

  // result word stays still until the next frame, so the link side
  // may read it once it has seen the valid level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result_r <= WORD_RST;
      result_valid_r <= 1'b0;
    end
    else if (cs_fall || cs_rise)
      result_valid_r <= 1'b0;
    else if (take)
    begin
      result_r <= out_if.data; // [R14]
      result_valid_r <= 1'b1;
    end
  end

  assign powered = powered_r;
  assign conv_busy = busy_r;
  assign osc_running = osc_run_r;

  // serial clock domain: counters and output shifter
  // chip select high clears this side; sclk may stop outside frames
  logic [4:0] rise_cnt_r;
  logic [4:0] fall_cnt_r;
  logic rv_meta_r;
  logic rv_sync_r;
  logic dout_r;
  logic [WORD_BITS-1:0] shift_r;

  // rising edges: count, and raise the external conversion request
  // one flop stage per edge, so any sclk up to 4.8 MHz is safe [R12]
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      rise_cnt_r <= CNT_RST;
      conv_req_r <= 1'b0;
    end
    else
    begin
      if (rise_cnt_r != FRAME_BITS)
        rise_cnt_r <= rise_cnt_r + 1'b1;
      if (rise_cnt_r == EXT_CONV_EDGE - 5'h01)
        conv_req_r <= 1'b1; // [R1]
    end
  end

  // result-valid level brought across by two flops
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      rv_meta_r <= 1'b0;
      rv_sync_r <= 1'b0;
    end
    else
    begin
      rv_meta_r <= result_valid_r;
      rv_sync_r <= rv_meta_r;
    end
  end

  // output shifter on falling edges; the host samples on rising ones
  // with the clock idling low, so the first bit is set up at select
  always_ff @(negedge sclk or posedge cs_n) // [R2] [R7] [R10]
  begin
    if (cs_n)
    begin
      fall_cnt_r <= CNT_RST;
      dout_r <= 1'b0;
      shift_r <= WORD_RST;
    end
    else
    begin
      if (fall_cnt_r != FRAME_BITS)
        fall_cnt_r <= fall_cnt_r + 1'b1;
      if (fall_cnt_r < LEAD_ZERO_BITS - 5'h01)
        dout_r <= 1'b0; // [R11]
      else if (fall_cnt_r == LEAD_ZERO_BITS - 5'h01)
      begin
        // empty fifo or late result: zeros rather than stale data
        dout_r <= rv_sync_r & result_r[WORD_BITS-1]; // [R11]
        shift_r <= rv_sync_r ? {result_r[WORD_BITS-2:0], 1'b0} : WORD_RST;
      end
      else
      begin
        dout_r <= shift_r[WORD_BITS-1]; // [R11]
        shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  assign dout = dout_r;

  // checks on both domains
  localparam int INT_CONV_MAX = 140;

  a_osc_ext_off: assert property (@(posedge clk) disable iff (reset) // [R4]
    !mode_r && !$past(mode_r) |-> !osc_running)
    else $error("oscillator running in external clock mode");

  a_cs_starts_conv: assert property (@(posedge clk) disable iff (reset) // [R8]
    cs_fall |=> state_r == ADCSP_CONV)
    else $error("chip select fall did not start a conversion");

  a_int_conv_time: assert property (@(posedge clk) disable iff (reset) // [R3]
    $rose(osc_running) ##1 !cs_sync_r[*2] |->
      ##[1:INT_CONV_MAX] (state_r == ADCSP_LOAD || cs_sync_r))
    else $error("internal conversion overran its tick budget");

  a_ext_wait_edge: assert property (@(posedge clk) disable iff (reset) // [R1]
    state_r == ADCSP_CONV && !mode_r && !ext_done && !cs_rise
      |=> state_r == ADCSP_CONV)
    else $error("external conversion ended without a serial edge");

  a_result_binary: assert property (@(posedge clk) disable iff (reset) // [R14]
    take |=> result_valid_r && result_r == $past(out_if.data))
    else $error("result word altered on its way out");

  a_zero_byte: assert property (@(negedge sclk) disable iff (cs_n) // [R11]
    fall_cnt_r < LEAD_ZERO_BITS |-> dout_r == 1'b0)
    else $error("leading byte not zero");

  a_msb_first: assert property (@(negedge sclk) // [R11] [R10]
    disable iff (cs_n)
    fall_cnt_r == LEAD_ZERO_BITS - 5'h01 && rv_sync_r
      |=> dout_r == $past(result_r[WORD_BITS-1]))
    else $error("result msb not presented after the zero byte");

  a_shift_order: assert property (@(negedge sclk) // [R2] [R11]
    disable iff (cs_n)
    fall_cnt_r > LEAD_ZERO_BITS && fall_cnt_r < FRAME_BITS
      |=> dout_r == $past(shift_r[WORD_BITS-1]))
    else $error("result bits out of order");

  a_ext_request: assert property (@(posedge sclk) disable iff (cs_n) // [R1]
    rise_cnt_r == EXT_CONV_EDGE - 5'h01 |=> conv_req_r)
    else $error("conversion request missing on its serial edge");

  a_power_follow: assert property (@(posedge clk) disable iff (reset) // [R8]
    powered == !$past(cs_sync_r))
    else $error("powered does not follow chip select");

  a_osc_in_conv: assert property (@(posedge clk) disable iff (reset) // [R3]
    osc_running |-> conv_busy)
    else $error("oscillator running outside a conversion");

  a_empty_zeros: assert property (@(negedge sclk) // [R11]
    disable iff (cs_n)
    fall_cnt_r == LEAD_ZERO_BITS - 5'h01 && !rv_sync_r
      |=> dout_r == 1'b0)
    else $error("result shown without a valid word");

  c_int_conv: cover property (@(posedge clk) disable iff (reset)
    mode_r && state_r == ADCSP_CONV ##[1:INT_CONV_MAX] take);

  c_ext_conv: cover property (@(posedge clk) disable iff (reset)
    !mode_r && ext_done ##[1:20] take);

  c_full_frame: cover property (@(negedge sclk) disable iff (cs_n)
    fall_cnt_r == 5'h17 && rv_sync_r);

  c_empty_frame: cover property (@(negedge sclk) disable iff (cs_n)
    fall_cnt_r == 5'h17 && !rv_sync_r);

  c_fifo_refill: cover property (@(posedge clk) disable iff (reset)
    !adc_ready ##1 adc_ready);
endmodule

// ---- testbench/adcsp_host_model.sv ----
// host-side serial master model for the adc readout port
// assumes: the bench calls frame(); dout is read on rising sclk
`timescale 1ns/1ps
module adcsp_host_model #(
  parameter int HALF_NS = 6, // bench link rate, 12 ns period
  parameter int WAKE_NS = 5000000 // reference wake-up time, ns
)(
  output logic sclk,
  output logic cs_n,
  input wire logic dout
);
  // set once the reference has had its wake-up time
  logic awake;

  // link idle: clock low, device deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    awake = 1'b0;
  end

  // one frame; the pause lets the conversion finish before bit 8
  task automatic frame(input int nbits, input int pause_ns,
                       output logic [25:0] rx, output logic [25:0] late);
    cs_n = 1'b0; // power up before any clock
    // first wake only: results are not trusted before the settle time
    if (!awake)
    begin
      #(WAKE_NS);
      awake = 1'b1;
    end
    #120;
    // three bytes, two more clocks for the flags
    for (int k = 0; k < nbits; k++)
    begin
      sclk = 1'b1;
      rx = {rx[24:0], dout}; // read mid bit on the rise
      #(HALF_NS - 1);
      late = {late[24:0], dout};
      #1;
      sclk = 1'b0;
      if (k == 3)
        #(pause_ns); // clock held still while converting
      #(HALF_NS);
    end
    cs_n = 1'b1; // held low for the whole transfer
    #240;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the adc serial readout port
// assumes: host model drives the link, bench feeds the result stream
`timescale 1ns/1ps
module tb_top
  import adcsp_pkg::*;
;
  logic clk;
  logic reset;
  logic int_clk_mode;
  logic [RES_BITS-1:0] adc_data;
  logic [FLAG_BITS-1:0] adc_flags;
  logic adc_valid;
  logic adc_ready;
  logic dout;
  logic powered;
  logic conv_busy;
  logic osc_running;
  logic sclk;
  logic cs_n;
  logic saw_osc;
  logic saw_busy;
  logic saw_pow;
  logic taken;
  logic [25:0] rx;
  logic [25:0] late;
  int miscompares;
  int n_checks;

  adcsp_top #(.DEPTH(FIFO_DEPTH)) dut (
    .clk(clk),
    .reset(reset),
    .sclk(sclk),
    .cs_n(cs_n),
    .int_clk_mode(int_clk_mode),
    .adc_data(adc_data),
    .adc_flags(adc_flags),
    .adc_valid(adc_valid),
    .adc_ready(adc_ready),
    .dout(dout),
    .powered(powered),
    .conv_busy(conv_busy),
    .osc_running(osc_running)
  );

  // reference wake-up scaled down so the run stays short
  adcsp_host_model #(.WAKE_NS(2000)) host (
    .sclk(sclk),
    .cs_n(cs_n),
    .dout(dout)
  );

  // 125 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // sticky status seen during a frame, cleared by the sequence
  always @(posedge clk)
  begin
    if (osc_running)
      saw_osc = 1'b1;
    if (conv_busy)
      saw_busy = 1'b1;
    if (powered)
      saw_pow = 1'b1;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [25:0] exp,
                     input logic [25:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      miscompares++;
    end
  endtask

  // write one word; taken is the ready level the next rise samples
  task automatic push(input logic [17:0] w, output logic ok);
    @(negedge clk);
    {adc_data, adc_flags} = w;
    adc_valid = 1'b1;
    ok = adc_ready;
  endtask

  // distinct words, zero and full scale among them
  function automatic logic [17:0] word(input int i);
    logic [15:0] d;
    d = (i == 1) ? 16'hFFFF : 16'h1357 * i[15:0];
    return {d, i[1:0]};
  endfunction

  // read one frame in the given clock mode
  task automatic read(input logic mode);
    @(negedge clk);
    int_clk_mode = mode;
    saw_osc = 1'b0;
    saw_busy = 1'b0;
    saw_pow = 1'b0;
    host.frame(26, mode ? 1500 : 300, rx, late);
    @(negedge clk);
    chk("late", {8'h00, late[17:0]}, {8'h00, rx[17:0]});
    chk("osc", {25'h0, mode}, {25'h0, saw_osc});
    chk("pow", 26'h1, {25'h0, saw_pow & ~powered});
    chk("dout idle", 26'h0, {25'h0, dout});
  endtask

  // watchdog sized well past the expected run of about 29 us
  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end

  // main sequence
  initial
  begin
    miscompares = 0;
    n_checks = 0;
    reset = 1'b1;
    int_clk_mode = 1'b0;
    adc_data = 16'h0000;
    adc_flags = 2'h0;
    adc_valid = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk("reset", 26'h8, {22'h0, adc_ready, powered, conv_busy,
        osc_running});
    // fill the fifo back to back, then one refused word
    for (int i = 0; i < 17; i++)
    begin
      push(word(i), taken);
      chk("taken", {25'h0, i < 16}, {25'h0, taken});
    end
    @(negedge clk);
    adc_valid = 1'b0;
    // drain in fifo order, alternating clock modes
    for (int i = 0; i < 16; i++)
    begin
      read(i[0]);
      chk("frame", {8'h00, word(i)}, rx);
      chk("busy", 26'h1, {25'h0, saw_busy});
      chk("ready", 26'h1, {25'h0, adc_ready});
    end
    // empty fifo: zeros, the refused word never appears
    read(1'b0);
    chk("empty", 26'h0, rx);
    complete_run();
  end
endmodule
